// *** design/mixer_pkg.sv ***
package mixer_pkg;
  // Datapath widths
  localparam int DATA_W   = 12;   // Multiplier operand width
  localparam int CAS_W    = 16;   // Chain input width
  localparam int ACC_W    = 24;   // Accumulator width
  localparam int SUM_W    = 16;   // Output word width
  localparam int SEL_W    = 4;    // Delay select width per port
  localparam int DEPTH    = 16;   // Delay pipeline stages per port
  localparam int NPORT    = 4;    // Ports A, B, C, D

  // Field positions
  localparam int CAS_SHIFT = 8;   // Chain input bit 0 weighs 2^8
  localparam int MSW_LO    = 8;   // Most significant word is acc[23:8]

  // Half LSB of a 16-bit result, added at 2^7
  localparam logic [23:0] ROUND_ADD = 24'h000080;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_DELAY_SEL = 4'h0;  // Four delay selects
  localparam logic [3:0] ADDR_ACC_VIEW  = 4'h4;  // Accumulator, read only

  // Values after reset
  localparam logic [15:0] DELAY_SEL_RST = 16'h0000;  // One clock on all
  localparam logic [31:0] RDATA_RST     = 32'h00000000;
endpackage

// *** design/port_delay_pipe.sv ***
`timescale 1ns/1ps
// One input port: enabled shift chain with a selectable tap
module port_delay_pipe
  import mixer_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int SW    = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             port_load_enable_n,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic [SW-1:0]    port_delay_select,
  output logic      [WIDTH-1:0] tap
);
  // Select code must reach exactly every stage
  if (DEPTH != (1 << SW)) begin : g_bad_depth
    $error("port_delay_pipe: DEPTH must equal 2**SW");
  end

  // Whole state of the port
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;  // Stage 0 is the newest
  } pipe_t;

  pipe_t s_r;    // Registered state
  pipe_t s_nxt;  // Next state

  // Shift only when enabled; otherwise the port value is dropped
  always_comb begin
    s_nxt = s_r;  // RULE2
    if (!port_load_enable_n) begin  // RULE1
      s_nxt.stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
        s_nxt.stage[i] = s_r.stage[i-1];
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Code 0 reads stage 0, one clock behind the port
  assign tap = s_r.stage[port_delay_select];  // RULE16

  property p_load_shift;
    @(posedge clk) disable iff (!resetn)
    !port_load_enable_n |=> s_r.stage[0] == $past(din);
  endproperty
  a_load_shift: assert property (p_load_shift)  // RULE1
    else $error("port pipeline did not take the input");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    port_load_enable_n |=> s_r == $past(s_r);
  endproperty
  a_hold: assert property (p_hold)  // RULE2
    else $error("port pipeline moved while disabled");
endmodule // port_delay_pipe

// *** design/word_swap_out.sv ***
`timescale 1ns/1ps
// Double output register with word toggling and output enable
module word_swap_out
  import mixer_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             word_swap,
  input  wire logic [ACC_W-1:0] acc_in,
  input  wire logic             output_enable_n,
  output logic      [SUM_W-1:0] sum_out,
  output logic                  sum_oe
);
  // Whole state of the output stage
  typedef struct packed {
    logic [SUM_W-1:0] msw;       // Captured upper word
    logic [SUM_W-1:0] lsw;       // Captured lower word
    logic             show_lsw;  // Next toggle shows the lower word
    logic [SUM_W-1:0] out;       // Word on the bus
  } swap_t;

  swap_t s_r;    // Registered state
  swap_t s_nxt;  // Next state

  // Word capture and toggling
  always_comb begin
    s_nxt = s_r;
    if (word_swap) begin
      // Normal flow: fresh words, upper one shown
      s_nxt.msw      = acc_in[ACC_W-1:MSW_LO];  // RULE12
      s_nxt.lsw      = acc_in[SUM_W-1:0];
      s_nxt.out      = s_r.msw;
      s_nxt.show_lsw = 1'b1;
    end else begin  // RULE14
      // Frozen words, alternate which one is shown
      s_nxt.out      = s_r.show_lsw ? s_r.lsw : s_r.msw;  // RULE13
      s_nxt.show_lsw = ~s_r.show_lsw;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Enable acts without the clock, on purpose not synchronised
  assign sum_out = s_r.out;
  assign sum_oe  = ~output_enable_n;  // RULE15

  property p_msw_shown;
    @(posedge clk) disable iff (!resetn)
    word_swap |=> sum_out == $past(s_r.msw);
  endproperty
  a_msw_shown: assert property (p_msw_shown)  // RULE12
    else $error("upper word not shown in normal flow");

  property p_toggle;
    @(posedge clk) disable iff (!resetn)
    !word_swap ##1 !word_swap |-> s_r.show_lsw != $past(s_r.show_lsw);
  endproperty
  a_toggle: assert property (p_toggle)  // RULE13
    else $error("output words do not alternate");

  property p_frozen;
    @(posedge clk) disable iff (!resetn)
    !word_swap |=> s_r.msw == $past(s_r.msw) && s_r.lsw == $past(s_r.lsw);
  endproperty
  a_frozen: assert property (p_frozen)  // RULE14
    else $error("output words reloaded while toggling");
endmodule // word_swap_out

// *** design/product_accumulator.sv ***
`timescale 1ns/1ps
// Summary of operation
// RULE1: Enabled port shifts input into its pipeline
// RULE2: Disabled port holds pipeline, drops port value
// RULE3: Negate controls invert first or second product
// RULE4: Negate controls bypass the port delay pipelines
// RULE5: Round request rounds sum to 16 bits
// RULE6: Rounding only on first accumulation cycle
// RULE7: Bypass feeds chain input with least delay
// RULE8: Zero delays: output six clocks after inputs
// RULE9: Chain enable low adds chain input, else ignored
// RULE10: Keep low starts a fresh sum
// RULE11: Keep high accumulates, rounding disabled
// RULE12: Swap high shows most significant word
// RULE13: Swap low alternates lower and upper words
// RULE14: Swap low freezes output word registers
// RULE15: Output enable drives bus asynchronously
// RULE16: Delay select 0 is one clock, 15 sixteen
// RULE17: All data values are two's complement
// RULE18: Accumulator wraps, no saturation or flag
module product_accumulator
  import mixer_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Data ports A, B, C, D, bit slices in that order from 0
  input  wire logic [NPORT*DATA_W-1:0] port_data,
  input  wire logic [NPORT-1:0]        port_load_enable_n,
  input  wire logic [CAS_W-1:0]        cascade_in,
  // Per clock controls
  input  wire logic                    negate_first_product,
  input  wire logic                    negate_second_product,
  input  wire logic                    round_request,
  input  wire logic                    cascade_bypass,
  input  wire logic                    chain_input_enable_n,
  input  wire logic                    sum_keep,
  input  wire logic                    word_swap,
  input  wire logic                    output_enable_n,
  // Sum bus, three-state as value plus enable
  output logic      [SUM_W-1:0]        sum_out,
  output logic                         sum_oe,
  // Avalon-MM slave
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest
);
  // Whole state of the datapath and the bus slave
  typedef struct packed {
    // Bus slave
    logic [NPORT*SEL_W-1:0] sel;      // Delay selects, A in low nibble
    logic                   ack;      // Second cycle of an access
    logic [31:0]            rdata;    // Read data register
    // Stage 1: registered controls and chain input
    logic                   neg_ab1;  // Negate first product
    logic                   neg_cd1;  // Negate second product
    logic                   rnd1;     // Round request
    logic                   keep1;    // Accumulate control
    logic                   byp1;     // Chain bypass
    logic                   swap1;    // Output word swap
    logic [CAS_W-1:0]       cas1;     // Chain input, zero when disabled
    // Stage 2: products
    logic [ACC_W-1:0]       prod_ab2; // Signed A times B
    logic [ACC_W-1:0]       prod_cd2; // Signed C times D
    logic                   rnd2;
    logic                   keep2;
    logic [CAS_W-1:0]       cas2;
    // Stage 3: sum of products
    logic [ACC_W-1:0]       sum3;
    logic                   keep3;
    logic [CAS_W-1:0]       cas3;
    // Stage 4: accumulator
    logic [ACC_W-1:0]       acc4;
  } core_t;

  core_t s_r;    // Registered state
  core_t s_nxt;  // Next state

  logic [NPORT*DATA_W-1:0] taps;      // Selected pipeline taps
  logic [ACC_W-1:0]        raw_ab;    // Unnegated A times B
  logic [ACC_W-1:0]        raw_cd;    // Unnegated C times D
  logic [ACC_W-1:0]        cas_term;  // Chain word at accumulator weight
  logic [CAS_W-1:0]        cas_pick;  // Chain word entering accumulator
  logic                    hit_sel;   // Access to the select register
  logic                    hit_acc;   // Access to the accumulator view
  logic [31:0]             rd_mux;    // Read value before registering

  // One delay pipeline per port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    port_delay_pipe #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH),
      .SW    (SEL_W)
    ) u_pipe (
      .clk                (clk),
      .resetn             (resetn),
      .port_load_enable_n (port_load_enable_n[p]),
      .din                (port_data[p*DATA_W +: DATA_W]),
      .port_delay_select  (s_r.sel[p*SEL_W +: SEL_W]),
      .tap                (taps[p*DATA_W +: DATA_W])
    );
  end

  // Signed 12 by 12 products fit 24 bits exactly
  assign raw_ab = ACC_W'($signed(taps[0*DATA_W +: DATA_W]) *
                         $signed(taps[1*DATA_W +: DATA_W]));  // RULE17
  assign raw_cd = ACC_W'($signed(taps[2*DATA_W +: DATA_W]) *
                         $signed(taps[3*DATA_W +: DATA_W]));

  // Bypass skips two alignment stages of the chain path
  assign cas_pick = s_r.byp1 ? s_r.cas1 : s_r.cas3;  // RULE7
  // Chain bit 0 weighs 2^8, so the sign lands in bit 23
  assign cas_term = {cas_pick, {CAS_SHIFT{1'b0}}};  // RULE17

  // Address decode; other offsets read zero, writes dropped
  assign hit_sel = avs_address == ADDR_DELAY_SEL;
  assign hit_acc = avs_address == ADDR_ACC_VIEW;

  // Read value; upper bits read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_sel) begin
      rd_mux[NPORT*SEL_W-1:0] = s_r.sel;
    end else if (hit_acc) begin
      rd_mux[ACC_W-1:0] = s_r.acc4;
    end
  end

  // Next state of the whole datapath
  always_comb begin
    s_nxt = s_r;

    // Bus: one wait cycle, then the access completes
    s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
    if (avs_read && !s_r.ack) begin
      s_nxt.rdata = rd_mux;
    end
    if (avs_write && s_r.ack && hit_sel) begin
      // Selects power up unknown on real parts; here reset to zero
      if (avs_byteenable[0]) begin
        s_nxt.sel[7:0] = avs_writedata[7:0];  // RULE16
      end
      if (avs_byteenable[1]) begin
        s_nxt.sel[15:8] = avs_writedata[15:8];
      end
    end

    // Stage 1: negates are registered here, never delayed by selects
    s_nxt.neg_ab1 = negate_first_product;  // RULE4
    s_nxt.neg_cd1 = negate_second_product;
    s_nxt.rnd1    = round_request;
    s_nxt.keep1   = sum_keep;
    s_nxt.byp1    = cascade_bypass;
    s_nxt.swap1   = word_swap;
    // Disabled chain input enters as zero
    s_nxt.cas1    = chain_input_enable_n ? '0 : cascade_in;  // RULE9

    // Stage 2: products, negated where requested
    s_nxt.prod_ab2 = s_r.neg_ab1 ? ACC_W'(-raw_ab) : raw_ab;  // RULE3
    s_nxt.prod_cd2 = s_r.neg_cd1 ? ACC_W'(-raw_cd) : raw_cd;
    s_nxt.rnd2     = s_r.rnd1;
    s_nxt.keep2    = s_r.keep1;
    s_nxt.cas2     = s_r.cas1;

    // Stage 3: sum, half LSB only on a fresh sum
    s_nxt.sum3 = ACC_W'(s_r.prod_ab2 + s_r.prod_cd2);  // RULE18
    if (s_r.rnd2 && !s_r.keep2) begin
      s_nxt.sum3 = ACC_W'(s_r.prod_ab2 + s_r.prod_cd2
                          + ROUND_ADD);  // RULE5 RULE6
    end
    s_nxt.keep3 = s_r.keep2;
    s_nxt.cas3  = s_r.cas2;

    // Stage 4: wraps silently, there is no overflow flag
    if (s_r.keep3) begin
      s_nxt.acc4 = ACC_W'(s_r.acc4 + s_r.sum3 + cas_term);  // RULE11 RULE18
    end else begin
      s_nxt.acc4 = ACC_W'(s_r.sum3 + cas_term);  // RULE10
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r       <= '0;
      s_r.sel   <= DELAY_SEL_RST;
      s_r.rdata <= RDATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Output words: loaded one clock after stage 4, shown one later
  word_swap_out u_out (
    .clk             (clk),
    .resetn          (resetn),
    .word_swap       (s_r.swap1),
    .acc_in          (s_r.acc4),
    .output_enable_n (output_enable_n),
    .sum_out         (sum_out),
    .sum_oe          (sum_oe)
  );  // RULE8

  // Bus outputs
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign avs_readdata    = s_r.rdata;

  property p_negate_ab;
    @(posedge clk) disable iff (!resetn)
    s_r.neg_ab1 |=> s_r.prod_ab2 == ACC_W'(-$past(raw_ab));
  endproperty
  a_negate_ab: assert property (p_negate_ab)  // RULE3
    else $error("first product not negated");

  property p_negate_cd_off;
    @(posedge clk) disable iff (!resetn)
    !s_r.neg_cd1 |=> s_r.prod_cd2 == $past(raw_cd);
  endproperty
  a_negate_cd_off: assert property (p_negate_cd_off)  // RULE3
    else $error("second product changed without negate");

  property p_round_fresh;
    @(posedge clk) disable iff (!resetn)
    round_request && !sum_keep ##2 1 |=>
      s_r.sum3 == ACC_W'($past(s_r.prod_ab2) + $past(s_r.prod_cd2)
                         + ROUND_ADD);
  endproperty
  a_round_fresh: assert property (p_round_fresh)  // RULE5
    else $error("rounding missing on fresh sum");

  property p_round_off_keep;
    @(posedge clk) disable iff (!resetn)
    s_r.keep2 |=> s_r.sum3 == ACC_W'($past(s_r.prod_ab2)
                                     + $past(s_r.prod_cd2));
  endproperty
  a_round_off_keep: assert property (p_round_off_keep)  // RULE6 RULE11
    else $error("rounding applied while accumulating");

  property p_chain_off;
    @(posedge clk) disable iff (!resetn)
    chain_input_enable_n |=> s_r.cas1 == '0 ##2 s_r.cas3 == '0;
  endproperty
  a_chain_off: assert property (p_chain_off)  // RULE9
    else $error("disabled chain input reached the sum");

  property p_bypass;
    @(posedge clk) disable iff (!resetn)
    s_r.byp1 && !s_r.keep3 |=>
      s_r.acc4 == ACC_W'($past(s_r.sum3) + {$past(s_r.cas1), 8'h00});
  endproperty
  a_bypass: assert property (p_bypass)  // RULE7
    else $error("bypass did not take the early chain word");

  property p_fresh;
    @(posedge clk) disable iff (!resetn)
    !sum_keep ##3 !s_r.byp1 |=>
      s_r.acc4 == ACC_W'($past(s_r.sum3) + {$past(s_r.cas3), 8'h00});
  endproperty
  a_fresh: assert property (p_fresh)  // RULE10
    else $error("old total not cleared on fresh sum");

  property p_accumulate;
    @(posedge clk) disable iff (!resetn)
    s_r.keep3 && !s_r.byp1 |=>
      s_r.acc4 == ACC_W'($past(s_r.acc4) + $past(s_r.sum3)
                         + {$past(s_r.cas3), 8'h00});
  endproperty
  a_accumulate: assert property (p_accumulate)  // RULE11
    else $error("accumulator did not add to the total");

  property p_bus_wait;
    @(posedge clk) disable iff (!resetn)
    (avs_read || avs_write) && !s_r.ack |=> !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus access not answered after one wait");

  // Second product passes negated when asked
  property p_negate_cd;
    @(posedge clk) disable iff (!resetn)
    s_r.neg_cd1 |=> s_r.prod_cd2 == ACC_W'(-$past(raw_cd));
  endproperty
  a_negate_cd: assert property (p_negate_cd)  // RULE3
    else $error("second product not negated");

  // First product untouched without negate
  property p_negate_ab_off;
    @(posedge clk) disable iff (!resetn)
    !s_r.neg_ab1 |=> s_r.prod_ab2 == $past(raw_ab);
  endproperty
  a_negate_ab_off: assert property (p_negate_ab_off)  // RULE3
    else $error("first product changed without negate");

  // Enabled chain word is taken as given
  property p_chain_on;
    @(posedge clk) disable iff (!resetn)
    !chain_input_enable_n |=> s_r.cas1 == $past(cascade_in);
  endproperty
  a_chain_on: assert property (p_chain_on)  // RULE9
    else $error("enabled chain input not taken");

  // No half LSB without a request
  property p_round_off;
    @(posedge clk) disable iff (!resetn)
    !s_r.rnd2 |=> s_r.sum3 == ACC_W'($past(s_r.prod_ab2)
                                     + $past(s_r.prod_cd2));
  endproperty
  a_round_off: assert property (p_round_off)  // RULE5
    else $error("rounding applied without request");

  // Keep travels with the data of its own clock
  property p_keep_align;
    @(posedge clk) disable iff (!resetn)
    sum_keep |=> s_r.keep1 ##2 s_r.keep3;
  endproperty
  a_keep_align: assert property (p_keep_align)  // RULE11
    else $error("accumulate control out of step with data");

  // A landed write with both low byte enables sets all four selects
  property p_sel_write;
    @(posedge clk) disable iff (!resetn)
    avs_write && s_r.ack && hit_sel && avs_byteenable[1:0] == 2'h3 |=>
      s_r.sel == $past(avs_writedata[15:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)  // RULE16
    else $error("delay select write did not land");

  // Accumulator view returns the stage 4 total
  property p_acc_read;
    @(posedge clk) disable iff (!resetn)
    avs_read && !s_r.ack && hit_acc |=>
      avs_readdata == {8'h00, $past(s_r.acc4)};
  endproperty
  a_acc_read: assert property (p_acc_read)
    else $error("accumulator view read wrong");

  // Unmapped offsets read as zero
  property p_unmapped_read;
    @(posedge clk) disable iff (!resetn)
    avs_read && !s_r.ack && !hit_sel && !hit_acc |=>
      avs_readdata == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped offset read not zero");
endmodule // product_accumulator

// *** verif/sum_bus_listener.sv ***
`timescale 1ns/1ps
// Receiver at the far end of the three-state sum bus
module sum_bus_listener
  import mixer_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sum_oe,
  input  wire logic [SUM_W-1:0] sum_out,
  output logic      [SUM_W-1:0] bus_level
);
  logic [SUM_W-1:0] last_r;  // Last driven word

  // Remember what the device drove
  always_ff @(posedge clk) begin
    if (sum_oe) begin
      last_r <= sum_out;
    end
  end

  // Released bus shows the inverse, so stale data never looks valid
  always_comb begin
    bus_level = sum_oe ? sum_out : ~last_r;
  end
endmodule // sum_bus_listener

// *** verif/tb_dual_product_accumulator_ctrl.sv ***
`timescale 1ns/1ps
module tb_dual_product_accumulator_ctrl import mixer_pkg::*;;
  typedef struct {int prod; int cas; bit keep; bit rnd; bit bp;} ent_t;
  typedef struct {int acc; bit ok;} exp_t;
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  logic [NPORT*DATA_W-1:0] port_data = '0;
  logic [NPORT-1:0]        port_load_enable_n = '1;
  logic [CAS_W-1:0]        cascade_in = '0;
  logic                    negate_first_product = 1'b0;
  logic                    negate_second_product = 1'b0;
  logic                    round_request = 1'b0;
  logic                    cascade_bypass = 1'b0;
  logic                    chain_input_enable_n = 1'b1;
  logic                    sum_keep = 1'b0;
  logic                    word_swap = 1'b1;
  logic                    output_enable_n = 1'b0;
  logic [SUM_W-1:0]        sum_out, bus_level;
  logic                    sum_oe, avs_waitrequest;
  logic [3:0]              avs_address = '0, avs_byteenable = '0;
  logic                    avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]             avs_writedata = '0, avs_readdata;
  int   errors = 0, checks_done = 0, seed = 96, gate = 0;
  int   pipe [NPORT][DEPTH];     // Model of the port pipelines
  int   sel [NPORT];             // Model delay selects
  int   acc_m = 0;               // Model accumulator
  bit   known = 1'b1;            // Model accumulator trusted
  bit   bp_mode = 1'b0, swap_mode = 1'b1, hold_const = 1'b0;
  ent_t hq[$];                   // Product terms awaiting chain word
  exp_t eq[$];                   // Results awaiting the output

  product_accumulator dut_u (.clk(clk), .resetn(resetn),
    .port_data(port_data), .port_load_enable_n(port_load_enable_n),
    .cascade_in(cascade_in), .negate_first_product(negate_first_product),
    .negate_second_product(negate_second_product),
    .round_request(round_request), .cascade_bypass(cascade_bypass),
    .chain_input_enable_n(chain_input_enable_n), .sum_keep(sum_keep),
    .word_swap(word_swap), .output_enable_n(output_enable_n),
    .sum_out(sum_out), .sum_oe(sum_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  sum_bus_listener far_u (.clk(clk), .sum_oe(sum_oe), .sum_out(sum_out),
    .bus_level(bus_level));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One comparison
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] sn);
    checks_done++;
    if (sn !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
      errors++;
    end
  endtask

  // Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      errors++;  // Slave never answered
      wrap_up();
    end
  endtask

  // Model takes the sampled inputs, then new stimulus is launched
  always @(posedge clk) begin
    int p, s, prod, cv;
    logic [31:0] r1, r2, r3;
    if (resetn) begin
      for (p = 0; p < NPORT; p++) begin
        if (!port_load_enable_n[p]) begin
          for (s = DEPTH - 1; s > 0; s--) pipe[p][s] = pipe[p][s-1];
          pipe[p][0] = $signed(port_data[p*DATA_W+:DATA_W]);
        end
      end
      // Negates from this clock, operands from the taps
      prod = (negate_first_product ? -1 : 1) * pipe[0][sel[0]] *
             pipe[1][sel[1]] + (negate_second_product ? -1 : 1) *
             pipe[2][sel[2]] * pipe[3][sel[3]];
      cv = chain_input_enable_n ? 0 : $signed(cascade_in) * 256;
      hq.push_back('{prod, cv, sum_keep, round_request && !sum_keep,
                     cascade_bypass});
      if (hq.size() == 3) begin
        // Bypass pairs a later chain word with these products
        cv = hq[0].bp ? hq[2].cas : hq[0].cas;
        acc_m = ((hq[0].keep ? acc_m : 0) + hq[0].prod +
                 (hq[0].rnd ? 128 : 0) + cv) & 32'hFFFFFF;
        known = hq[0].bp == hq[1].bp && hq[1].bp == hq[2].bp &&
                (known || !hq[0].keep);
        eq.push_back('{acc_m, known});
        void'(hq.pop_front());
      end
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      if (hold_const) begin
        port_data <= {24'h000000, 12'h7FF, 12'h7FF};
        port_load_enable_n <= '0;
        {negate_first_product, negate_second_product} <= 2'h0;
        {round_request, sum_keep, cascade_bypass} <= 3'h0;
        chain_input_enable_n <= 1'b1;
      end else begin
        port_data <= {r1, r2[15:0]};
        cascade_in <= r2[31:16];
        port_load_enable_n <= r3[3:0] & r3[7:4];
        {negate_first_product, negate_second_product} <= r3[9:8];
        {round_request, chain_input_enable_n} <= r3[11:10];
        sum_keep <= r3[12] | r3[13];
        cascade_bypass <= bp_mode;
      end
      output_enable_n <= r3[14];
      word_swap <= swap_mode;
    end
  end

  // Results are compared where they have settled
  always @(negedge clk) begin
    exp_t e;
    if (resetn) begin
      if (eq.size() > 3) begin
        e = eq.pop_front();
        if (e.ok && gate == 0) begin
          chk("sum_out", 32'(e.acc[23:8]), {16'h0, sum_out});
        end
      end
      if (gate > 0) gate--;
      chk("sum_oe", {31'h0, ~output_enable_n}, {31'h0, sum_oe});
      if (!output_enable_n) begin
        chk("bus", {16'h0, sum_out}, {16'h0, bus_level});
      end
    end
  end

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [15:0] cfg [2];
    logic [15:0] w, lsw, msw;
    int k, p;
    cfg = '{16'h0F30, 16'h0000};
    for (p = 0; p < NPORT; p++) sel[p] = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, ADDR_DELAY_SEL, 32'h0, rd);
    chk("sel reset", {16'h0, DELAY_SEL_RST}, rd);
    repeat (300) @(posedge clk);
    bp_mode <= 1'b1;
    repeat (300) @(posedge clk);
    bp_mode <= 1'b0;
    for (k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_DELAY_SEL, {16'h0, cfg[k]}, rd);
      for (p = 0; p < NPORT; p++) sel[p] = cfg[k][p*4+:4];
      gate = 60;
      bus(1'b0, ADDR_DELAY_SEL, 32'h0, rd);
      chk("sel", {16'h0, cfg[k]}, rd);
      repeat (300) @(posedge clk);
    end
    // Steady sum, then the register view and refused accesses
    hold_const <= 1'b1;
    repeat (12) @(posedge clk);
    bus(1'b1, ADDR_ACC_VIEW, 32'h00FFFFFF, rd);
    bus(1'b1, 4'h8, 32'h00001234, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, ADDR_ACC_VIEW, 32'h0, rd);
    chk("acc view", 32'(acc_m), rd);
    lsw = acc_m[15:0];
    msw = acc_m[23:8];
    // Toggle mode while fresh data keeps arriving
    gate = 40;
    swap_mode <= 1'b0;
    hold_const <= 1'b0;
    repeat (4) @(negedge clk);
    w = sum_out;
    chk("swap first", {16'h0, lsw}, {16'h0, w});
    repeat (7) begin
      @(negedge clk);
      chk("swap word", {16'h0, (w === lsw) ? msw : lsw}, {16'h0, sum_out});
      w = sum_out;
    end
    @(posedge clk);
    swap_mode <= 1'b1;
    gate = 12;
    repeat (200) @(posedge clk);
    wrap_up();
  end
endmodule // tb_dual_product_accumulator_ctrl
